// ==== src/disp_cmd_pkg.sv ====
/*
 Constants shared by the host bus master and the display command end:
 command codes, field positions, reset values and strobe timing counts.
 Assumes both ends run on clk_sys, which also serves as the reference clock.
*/
// Notes on behaviour
// - PLL status query returns lock in bit two.
// - Lock bit reads zero unlocked, one locked.
// - Deep sleep command enters sleep, halts PLL.
// - Two dummy reads end sleep, after second.
// - Ratio command: three bytes, nibble then bytes.
// - Ratio resets to upper 0111, lower ones.
// - Pixel clock equals PLL times (ratio+1)/2^20.
// - Ratio readback returns same three-byte layout.
// - Format command: one byte, low three bits.
// - Format codes decode; reserved seven; reset 101.
// - Format readback returns current code.
// - Host strobe low one, high one cycle.
// - Host waits five cycles for read data.
package disp_cmd_pkg;

	////////////////////////////////////////////////////////////////////////
	// Command codes.
	localparam logic [7:0] CMD_PLL_STATUS = 8'hE4;
	localparam logic [7:0] CMD_DEEP_SLEEP = 8'hE5;
	localparam logic [7:0] CMD_SET_PCLK   = 8'hE6;
	localparam logic [7:0] CMD_GET_PCLK   = 8'hE7;
	localparam logic [7:0] CMD_SET_FMT    = 8'hF0;
	localparam logic [7:0] CMD_GET_FMT    = 8'hF1;

	////////////////////////////////////////////////////////////////////////
	// Fields and reset values.
	localparam int          LOCK_BIT      = 2;
	localparam logic [19:0] RATIO_RST     = 20'h7FFFF;
	localparam logic [2:0]  FMT_RST       = 3'h5;
	localparam logic [2:0]  FMT_RESERVED  = 3'h7;
	localparam int          WAKE_READS    = 2;

	////////////////////////////////////////////////////////////////////////
	// Strobe timing, in reference clock cycles, then in clk_sys cycles.
	localparam int STRB_LOW_TCYC   = 1;
	localparam int STRB_HIGH_TCYC  = 1;
	localparam int FIRST_RD_TCYC   = 5;
	localparam int SYS_PER_TCYC    = 1;
	localparam logic [2:0] STRB_LOW_CYC  = 3'(STRB_LOW_TCYC * SYS_PER_TCYC);
	localparam logic [2:0] STRB_HIGH_CYC = 3'(STRB_HIGH_TCYC * SYS_PER_TCYC);
	localparam logic [2:0] FIRST_RD_CYC  = 3'(FIRST_RD_TCYC * SYS_PER_TCYC);

	////////////////////////////////////////////////////////////////////////
	// Host register map on APB, and command register fields.
	localparam logic [7:0] HOST_CMD_OFS   = 8'h00;
	localparam logic [7:0] HOST_STAT_OFS  = 8'h04;
	localparam logic [7:0] HOST_RDATA_OFS = 8'h08;
	localparam int         CMD_DC_BIT     = 8;
	localparam int         CMD_READ_BIT   = 9;
	localparam int         STAT_BUSY_BIT  = 0;

endpackage

// ==== src/host_bus_if.sv ====
/*
 Parallel command/parameter bus between host and display command end.
 Assumes the bench joins both modports; the data wire is resolved here.
*/
`timescale 1ns/1ps
`default_nettype none
interface host_bus_if;
	logic       cs_n;
	logic       dc;
	logic       rd_n;
	logic       wr_n;
	logic [7:0] hd_out;
	logic       hd_oe;
	logic [7:0] dd_out;
	logic       dd_oe;
	logic [7:0] data;

	// Host drive wins; an undriven bus reads as zero.
	assign data = hd_oe ? hd_out : (dd_oe ? dd_out : 8'h00);

	modport host (
		output cs_n, dc, rd_n, wr_n, hd_out, hd_oe,
		input  data
	);
	modport device (
		input  cs_n, dc, rd_n, wr_n, data,
		output dd_out, dd_oe
	);
endinterface
`default_nettype wire

// ==== src/disp_cmd_device.sv ====
/*
 Display controller command end: PLL status, deep sleep, pixel clock
 ratio and pixel data format commands, plus the pixel clock generator.
 Assumes bus pins are synchronous to clk_sys and that an outside PLL
 setup handler pulses pll_restart when the host re-enables the PLL.
*/
// Added by the designer: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module disp_cmd_device (
	input  wire logic        clk_sys,
	input  wire logic        rstn,
	host_bus_if.device       bus,
	input  wire logic        pll_locked,
	input  wire logic        pll_restart,
	output logic [19:0]      pixel_clock_ratio_r,
	output logic [2:0]       pixel_format_r,
	output logic             deep_sleep_r,
	output logic             pll_stop_r,
	output logic             use_pll_clk_r,
	output logic             panel_pixel_clock_out_r
);

	typedef enum logic {PWR_AWAKE, PWR_SLEEP} pwr_e;

	pwr_e        pwr_r;
	logic        wake_cnt_r;
	logic        wr_n_q_r;
	logic        rd_n_q_r;
	logic [7:0]  cmd_r;
	logic [1:0]  idx_r;
	logic [11:0] ratio_hi_r;
	logic [19:0] acc_r;
	logic [7:0]  dd_out_r;
	logic        dd_oe_r;
	logic        wr_take;
	logic        rd_take;
	logic        rd_done;
	logic        awake;
	logic        cmd_wr;
	logic        par_wr;
	logic        par_rd;
	logic        lock_bit;
	logic [7:0]  rd_byte;

	// A code is usable when it names a real bus width.
	function automatic logic fmt_known(input logic [2:0] code);
		fmt_known = (code != disp_cmd_pkg::FMT_RESERVED);
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Strobe edge detection; pins are already synchronous to clk_sys.
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			wr_n_q_r <= 1'b1;
			rd_n_q_r <= 1'b1;
		end else begin
			wr_n_q_r <= bus.wr_n;
			rd_n_q_r <= bus.rd_n;
		end
	end

	// An access is taken on the falling strobe while chip select is low.
	assign wr_take = !bus.cs_n && wr_n_q_r && !bus.wr_n;
	assign rd_take = !bus.cs_n && rd_n_q_r && !bus.rd_n;
	assign rd_done = !rd_n_q_r && bus.rd_n;
	assign awake   = (pwr_r == PWR_AWAKE);
	assign cmd_wr  = wr_take && !bus.dc && awake;
	assign par_wr  = wr_take && bus.dc && awake;
	assign par_rd  = rd_take && bus.dc && awake;

	////////////////////////////////////////////////////////////////////////
	// Power state. Every access in sleep is a dummy; the second read's end
	// wakes the device, so a single stray read never does.
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			pwr_r        <= PWR_AWAKE;
			wake_cnt_r   <= 1'b0;
			deep_sleep_r <= 1'b0;
		end else begin
			case (pwr_r)
				PWR_AWAKE: begin
					if (cmd_wr && bus.data == disp_cmd_pkg::CMD_DEEP_SLEEP) begin
						pwr_r        <= PWR_SLEEP;
						wake_cnt_r   <= 1'b0;
						deep_sleep_r <= 1'b1;
					end
				end
				PWR_SLEEP: begin
					if (rd_done) begin
						if (wake_cnt_r) begin
							pwr_r        <= PWR_AWAKE;
							deep_sleep_r <= 1'b0;
						end
						wake_cnt_r <= !wake_cnt_r;
					end
				end
				default: begin
					pwr_r        <= PWR_AWAKE;
					deep_sleep_r <= 1'b0;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// PLL control. The stop request outlives sleep, so the block stays on
	// the reference clock until the PLL handler restarts the PLL.
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			pll_stop_r <= 1'b0;
		end else if (cmd_wr && bus.data == disp_cmd_pkg::CMD_DEEP_SLEEP) begin
			pll_stop_r <= 1'b1;
		end else if (pll_restart && awake) begin
			pll_stop_r <= 1'b0;
		end
	end

	// A halted PLL never reports lock, even if its output is stale.
	assign lock_bit = pll_locked && !pll_stop_r;

	// Clock select follows lock; the clock mux itself sits outside.
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			use_pll_clk_r <= 1'b0;
		end else begin
			use_pll_clk_r <= lock_bit && awake;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Command register and parameter index. Reads advance the index so a
	// multi-byte readback walks through its bytes.
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			cmd_r <= 8'h00;
			idx_r <= 2'h0;
		end else if (cmd_wr) begin
			cmd_r <= bus.data;
			idx_r <= 2'h0;
		end else if ((par_wr || par_rd) && idx_r != 2'h3) begin
			idx_r <= idx_r + 2'h1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Pixel clock ratio. Upper bytes wait in a shadow until the third
	// byte arrives, so the generator never sees a half-written ratio.
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			ratio_hi_r          <= disp_cmd_pkg::RATIO_RST[19:8];
			pixel_clock_ratio_r <= disp_cmd_pkg::RATIO_RST;
		end else if (par_wr && cmd_r == disp_cmd_pkg::CMD_SET_PCLK) begin
			case (idx_r)
				2'h0: ratio_hi_r[11:8] <= bus.data[3:0];
				2'h1: ratio_hi_r[7:0]  <= bus.data;
				2'h2: pixel_clock_ratio_r <= {ratio_hi_r, bus.data};
				default: ratio_hi_r <= ratio_hi_r;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Pixel data format; a reserved code leaves the width as it was.
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			pixel_format_r <= disp_cmd_pkg::FMT_RST;
		end else if (par_wr && cmd_r == disp_cmd_pkg::CMD_SET_FMT && idx_r == 2'h0
			&& fmt_known(bus.data[2:0])) begin
			pixel_format_r <= bus.data[2:0];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Readback byte for the current command and parameter index.
	always_comb begin
		rd_byte = 8'h00;
		case (cmd_r)
			disp_cmd_pkg::CMD_PLL_STATUS: begin
				if (idx_r == 2'h0) begin
					rd_byte[disp_cmd_pkg::LOCK_BIT] = lock_bit;
				end
			end
			disp_cmd_pkg::CMD_GET_PCLK: begin
				case (idx_r)
					2'h0: rd_byte = {4'h0, pixel_clock_ratio_r[19:16]};
					2'h1: rd_byte = pixel_clock_ratio_r[15:8];
					2'h2: rd_byte = pixel_clock_ratio_r[7:0];
					default: rd_byte = 8'h00;
				endcase
			end
			disp_cmd_pkg::CMD_GET_FMT: begin
				if (idx_r == 2'h0) begin
					rd_byte = {5'h00, pixel_format_r};
				end
			end
			default: rd_byte = 8'h00;
		endcase
	end

	// Data drive: loaded one cycle after the read strobe falls, released one
	// cycle after it rises. Dummy reads in sleep return zero.
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			dd_out_r <= 8'h00;
			dd_oe_r  <= 1'b0;
		end else if (rd_take) begin
			dd_out_r <= (awake && bus.dc) ? rd_byte : 8'h00;
			dd_oe_r  <= 1'b1;
		end else if (rd_done) begin
			dd_oe_r <= 1'b0;
		end
	end

	assign bus.dd_out = dd_out_r;
	assign bus.dd_oe  = dd_oe_r;

	////////////////////////////////////////////////////////////////////////
	// Pixel clock generator: a phase accumulator adding ratio+1 per cycle,
	// whose top bit toggles at f * (ratio + 1) / 2^20. Jitter is one clock
	// period, traded against needing no second clock domain.
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			acc_r                   <= 20'h00000;
			panel_pixel_clock_out_r <= 1'b0;
		end else if (!awake) begin
			panel_pixel_clock_out_r <= 1'b0;
		end else begin
			acc_r                   <= acc_r + pixel_clock_ratio_r + 20'h00001;
			panel_pixel_clock_out_r <= acc_r[19];
		end
	end

endmodule
`default_nettype wire

// ==== src/disp_host_master.sv ====
/*
 Host end: an APB slave whose command register makes one bus access on
 the parallel command/parameter bus, with the required strobe widths.
 Assumes APB and the display bus share clk_sys.
*/
`timescale 1ns/1ps
`default_nettype none
module disp_host_master (
	input  wire logic        clk_sys,
	input  wire logic        rstn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	host_bus_if.host         bus
);

	typedef enum logic [1:0] {H_IDLE, H_LOW, H_HIGH} hst_e;

	hst_e       st_r;
	logic [2:0] cnt_r;
	logic       rd_op_r;
	logic [7:0] rdata_r;
	logic       cs_n_r;
	logic       dc_r;
	logic       rd_n_r;
	logic       wr_n_r;
	logic [7:0] hd_out_r;
	logic       hd_oe_r;
	logic       setup;
	logic       busy;
	logic       mapped;
	logic       start;

	assign setup  = psel && !penable;
	assign busy   = (st_r != H_IDLE);
	assign mapped = paddr == disp_cmd_pkg::HOST_CMD_OFS
		|| paddr == disp_cmd_pkg::HOST_STAT_OFS
		|| paddr == disp_cmd_pkg::HOST_RDATA_OFS;
	// A command write takes effect at the completing access edge. One that
	// was accepted at setup (idle then) stays accepted, since nothing else can
	// start the sequencer between setup and access.
	assign start  = psel && penable && pready && pwrite && !pslverr
		&& paddr == disp_cmd_pkg::HOST_CMD_OFS;

	////////////////////////////////////////////////////////////////////////
	// APB answer: ready in the cycle after setup, so no wait states.
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			prdata  <= 32'h00000000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= setup;
			pslverr <= setup && (!mapped
				|| (pwrite && busy && paddr == disp_cmd_pkg::HOST_CMD_OFS));
			prdata  <= 32'h00000000;
			if (setup && !pwrite && paddr == disp_cmd_pkg::HOST_STAT_OFS) begin
				prdata[disp_cmd_pkg::STAT_BUSY_BIT] <= busy;
			end else if (setup && !pwrite && paddr == disp_cmd_pkg::HOST_RDATA_OFS) begin
				prdata[7:0] <= rdata_r;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Access sequencer. Strobe and chip select fall together and rise
	// together; reads hold the strobe low until data has settled.
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			st_r     <= H_IDLE;
			cnt_r    <= 3'h0;
			rd_op_r  <= 1'b0;
			rdata_r  <= 8'h00;
			cs_n_r   <= 1'b1;
			dc_r     <= 1'b0;
			rd_n_r   <= 1'b1;
			wr_n_r   <= 1'b1;
			hd_out_r <= 8'h00;
			hd_oe_r  <= 1'b0;
		end else begin
			case (st_r)
				H_IDLE: begin
					if (start) begin
						rd_op_r  <= pwdata[disp_cmd_pkg::CMD_READ_BIT];
						dc_r     <= pwdata[disp_cmd_pkg::CMD_DC_BIT];
						hd_out_r <= pwdata[7:0];
						hd_oe_r  <= !pwdata[disp_cmd_pkg::CMD_READ_BIT];
						cs_n_r   <= 1'b0;
						rd_n_r   <= !pwdata[disp_cmd_pkg::CMD_READ_BIT];
						wr_n_r   <= pwdata[disp_cmd_pkg::CMD_READ_BIT];
						cnt_r    <= pwdata[disp_cmd_pkg::CMD_READ_BIT]
							? disp_cmd_pkg::FIRST_RD_CYC - 3'h1
							: disp_cmd_pkg::STRB_LOW_CYC - 3'h1;
						st_r     <= H_LOW;
					end
				end
				H_LOW: begin
					if (cnt_r == 3'h0) begin
						if (rd_op_r) begin
							rdata_r <= bus.data;
						end
						cs_n_r  <= 1'b1;
						rd_n_r  <= 1'b1;
						wr_n_r  <= 1'b1;
						hd_oe_r <= 1'b0;
						cnt_r   <= disp_cmd_pkg::STRB_HIGH_CYC - 3'h1;
						st_r    <= H_HIGH;
					end else begin
						cnt_r <= cnt_r - 3'h1;
					end
				end
				H_HIGH: begin
					if (cnt_r == 3'h0) begin
						st_r <= H_IDLE;
					end else begin
						cnt_r <= cnt_r - 3'h1;
					end
				end
				default: st_r <= H_IDLE;
			endcase
		end
	end

	assign bus.cs_n   = cs_n_r;
	assign bus.dc     = dc_r;
	assign bus.rd_n   = rd_n_r;
	assign bus.wr_n   = wr_n_r;
	assign bus.hd_out = hd_out_r;
	assign bus.hd_oe  = hd_oe_r;

endmodule
`default_nettype wire

// ==== sim/clock_sleep_pixel_format_cmds_checker.sv ====
/*
 Concurrent checks on the command/parameter bus and the command end state.
 Assumes the bench instantiates it beside the interface joining both ends.
*/
`timescale 1ns/1ps
`default_nettype none
module cmd_bus_checker (
	input wire logic       clk_sys,
	input wire logic       rstn,
	input wire logic       cs_n,
	input wire logic       dc,
	input wire logic       rd_n,
	input wire logic       wr_n,
	input wire logic       hd_oe,
	input wire logic       dd_oe,
	input wire logic [7:0] data,
	input wire logic       pll_locked,
	input wire logic [2:0] pixel_format_r,
	input wire logic       deep_sleep_r,
	input wire logic       pll_stop_r,
	input wire logic       use_pll_clk_r
);
	logic [1:0] wake_reads_r;

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rstn);

	// Reads taken while asleep; saturates so a stray fourth read cannot wrap to zero.
	always_ff @(posedge clk_sys) begin
		if (!rstn || !deep_sleep_r)
			wake_reads_r <= 2'h0;
		else if ($fell(rd_n) && wake_reads_r != 2'h3)
			wake_reads_r <= wake_reads_r + 2'h1;
	end

	////////////////////////////////////////////////////////////////////////////////
	wr_pulse_a: assert property ($fell(wr_n) |-> !cs_n ##1 (wr_n && cs_n))
		else $error("write strobe not one cycle low then high");
	rd_hold_a: assert property ($fell(rd_n) |-> !rd_n [*5])
		else $error("read strobe shorter than five cycles");
	rd_answer_a: assert property ($fell(rd_n) |=> dd_oe [*4])
		else $error("device data not driven before host latch");
	drive_excl_a: assert property (!(hd_oe && dd_oe))
		else $error("both ends drive the data bus");
	sleep_entry_a: assert property ($fell(wr_n) && !cs_n && !dc
		&& data == disp_cmd_pkg::CMD_DEEP_SLEEP |=>
		deep_sleep_r && pll_stop_r)
		else $error("deep sleep command not obeyed");
	stay_asleep_a: assert property (deep_sleep_r && wake_reads_r < 2'h2 |=> deep_sleep_r)
		else $error("woke before second dummy read");
	wake_count_a: assert property ($fell(deep_sleep_r) |-> wake_reads_r == 2'h2)
		else $error("wake without two dummy reads");
	fmt_keep_a: assert property ($fell(wr_n) && dc && data[2:0] == disp_cmd_pkg::FMT_RESERVED |=>
		$stable(pixel_format_r))
		else $error("reserved format code adopted");
	pll_halt_a: assert property (pll_stop_r |=> !use_pll_clk_r)
		else $error("PLL clock used while halted");
	lock_use_a: assert property (pll_locked && !pll_stop_r && !deep_sleep_r |=>
		use_pll_clk_r)
		else $error("locked PLL clock not taken");
endmodule
`default_nettype wire

// ==== sim/clock_sleep_pixel_format_cmds_tb.sv ====
/*
 Bench: host end and command end joined by the bus interface, driven over APB.
 Assumes clk_sys also serves as the reference clock.
*/
`timescale 1ns/1ps
`default_nettype none
module clock_sleep_pixel_format_cmds_tb;
	logic        clk_sys = 1'b0;
	logic        rstn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic        pll_locked = 1'b0;
	logic        pll_restart = 1'b0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [31:0] rd_q;
	logic        slv_err;
	logic [19:0] ratio;
	logic [2:0]  fmt;
	logic        sleep;
	logic        pll_stop;
	logic        use_pll;
	logic        pclk;
	logic        pclk_d = 1'b0;
	logic [19:0] r;
	logic [7:0]  exp_q[$];
	int          rises = 0;
	int          d;
	int          error_cnt = 0;
	int          comparisons = 0;
	int          seed = 32'hED29;

	host_bus_if hb ();
	disp_host_master disp_host_master_i (.clk_sys(clk_sys), .rstn(rstn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .bus(hb));
	disp_cmd_device disp_cmd_device_i (.clk_sys(clk_sys), .rstn(rstn), .bus(hb),
		.pll_locked(pll_locked), .pll_restart(pll_restart), .pixel_clock_ratio_r(ratio),
		.pixel_format_r(fmt), .deep_sleep_r(sleep), .pll_stop_r(pll_stop),
		.use_pll_clk_r(use_pll), .panel_pixel_clock_out_r(pclk));
	cmd_bus_checker cmd_bus_checker_i (.clk_sys(clk_sys), .rstn(rstn), .cs_n(hb.cs_n),
		.dc(hb.dc), .rd_n(hb.rd_n), .wr_n(hb.wr_n), .hd_oe(hb.hd_oe), .dd_oe(hb.dd_oe),
		.data(hb.data), .pll_locked(pll_locked), .pixel_format_r(fmt),
		.deep_sleep_r(sleep), .pll_stop_r(pll_stop), .use_pll_clk_r(use_pll));

	initial begin
		forever #2.5 clk_sys = ~clk_sys;
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// One APB transfer; the request is held until pready is seen at an edge.
	// Only the watchdog ends a wait that never gets an answer.
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do begin
			@(posedge clk_sys);
		end while (pready !== 1'b1);
		rd_q = prdata;
		slv_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// One display bus access, then busy is polled so the next order is legal.
	task automatic bus(input logic [7:0] b, input logic dc, input logic rd);
		apb(1'b1, disp_cmd_pkg::HOST_CMD_OFS, {22'h0, rd, dc, b});
		do begin
			apb(1'b0, disp_cmd_pkg::HOST_STAT_OFS, 32'h0);
		end while (rd_q[disp_cmd_pkg::STAT_BUSY_BIT] !== 1'b0);
		if (rd)
			apb(1'b0, disp_cmd_pkg::HOST_RDATA_OFS, 32'h0);
	endtask

	task automatic get(input logic [7:0] e);
		exp_q.push_back(e);
		bus(8'h00, 1'b1, 1'b1);
	endtask

	task automatic end_of_test();
		$display("error_cnt=%0d comparisons=%0d", error_cnt, comparisons);
		if (error_cnt == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// Each read answer retires the oldest expected byte; pixel clock rises are counted.
	always @(posedge clk_sys) begin
		pclk_d <= pclk;
		if (pclk && !pclk_d)
			rises <= rises + 1;
		if (psel && penable && pready === 1'b1 && !pwrite && paddr == disp_cmd_pkg::HOST_RDATA_OFS)
			check({24'h0, prdata[7:0]}, {24'h0, exp_q.pop_front()});
	end

	// Generous bound: the whole sequence needs well under ten thousand cycles.
	initial begin
		#200000;
		error_cnt++;
		end_of_test();
	end

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (8) @(posedge clk_sys);
		rstn <= 1'b1;
		check({12'h0, ratio}, 32'h7FFFF);
		check({29'h0, fmt}, 32'h5);
		bus(8'hE7, 1'b0, 1'b0);
		get(8'h07);
		get(8'hFF);
		get(8'hFF);
		apb(1'b0, 8'h10, 32'h0);
		check({31'h0, slv_err}, 32'h1);
		bus(8'hE4, 1'b0, 1'b0);
		get(8'h00);
		pll_locked <= 1'b1;
		bus(8'hE4, 1'b0, 1'b0);
		get(8'h04);
		// Ratio kept below half scale so the accumulator MSB makes a real square wave.
		r = {2'h1, 18'($random(seed))};
		bus(8'hE6, 1'b0, 1'b0);
		bus({4'h0, r[19:16]}, 1'b1, 1'b0);
		bus(r[15:8], 1'b1, 1'b0);
		bus(r[7:0], 1'b1, 1'b0);
		check({12'h0, ratio}, {12'h0, r});
		bus(8'hE7, 1'b0, 1'b0);
		get({4'h0, r[19:16]});
		get(r[15:8]);
		get(r[7:0]);
		d = rises;
		repeat (4096) @(posedge clk_sys);
		d = rises - d - int'(((longint'(r) + 1) * 4096) >>> 20);
		check({31'h0, d >= -1 && d <= 1}, 32'h1);
		for (int c = 0; c < 7; c++) begin
			bus(8'hF0, 1'b0, 1'b0);
			bus({5'h0, 3'(c)}, 1'b1, 1'b0);
			check({29'h0, fmt}, 32'(c));
			bus(8'hF1, 1'b0, 1'b0);
			get({5'h0, 3'(c)});
		end
		bus(8'hF0, 1'b0, 1'b0);
		bus(8'h07, 1'b1, 1'b0);
		check({29'h0, fmt}, 32'h6);
		bus(8'hE5, 1'b0, 1'b0);
		check({29'h0, sleep, pll_stop, pclk}, 32'h6);
		get(8'h00);
		check({31'h0, sleep}, 32'h1);
		get(8'h00);
		check({31'h0, sleep}, 32'h0);
		bus(8'hE4, 1'b0, 1'b0);
		get(8'h00);
		check({31'h0, use_pll}, 32'h0);
		pll_restart <= 1'b1;
		@(posedge clk_sys);
		pll_restart <= 1'b0;
		bus(8'hE4, 1'b0, 1'b0);
		get(8'h04);
		check({31'h0, use_pll}, 32'h1);
		// Every noted readback must have been answered and compared.
		repeat (2) @(posedge clk_sys);
		check(32'(exp_q.size()), 32'h0);
		end_of_test();
	end
endmodule
`default_nettype wire
